// >>> shared/irp_pkg.sv
// Constants for the register-pointer serial target port.
// Assumes a 10 MHz system clock and a serial bus clocked by the far controller.
package irp_pkg;
  localparam logic [6:0] TARGET_ADDR     = 7'h32;
  localparam logic [7:0] PTR_RESET       = 8'h00;
  localparam logic [7:0] PTR_STEP        = 8'h01;
  localparam logic [7:0] PTR_TOP         = 8'hFF;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0] LAST_TX_BIT     = 4'h7;
  localparam logic       DIR_WRITE       = 1'b0;
  localparam int         ADDR_WIDTH      = 8;
  localparam int         DATA_WIDTH      = 8;
  localparam int         CLK_PERIOD_NS   = 100;
  localparam int         STD_SCL_KHZ     = 100;
  localparam int         FAST_SCL_KHZ    = 400;
  localparam int         STD_SCL_CYC     = 1_000_000 / (STD_SCL_KHZ * CLK_PERIOD_NS);
  localparam int         FAST_SCL_CYC    = 1_000_000 / (FAST_SCL_KHZ * CLK_PERIOD_NS);
  localparam int         SYNC_STAGES     = 2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } irp_state_t;
endpackage : irp_pkg

// >>> shared/irp_mem_if.sv
// Connection between the serial target and its register store.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface irp_mem_if;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface : irp_mem_if

// >>> verilog/irp_reg_mem.sv
// Register store of 256 bytes with one write port and a registered read port.
// Assumes the controller holds the address steady while it expects read data.
`timescale 1ns/10ps
module irp_reg_mem
  import irp_pkg::*;
(
  input  wire logic clk,
  input  wire logic clkEn,
  input  wire logic sys_rst,
  irp_mem_if.mem    port
);
  logic [DATA_WIDTH-1:0] store [0:(1<<ADDR_WIDTH)-1];

  // Writes land on the addressed register.
  always_ff @(posedge clk) begin
    if (clkEn && port.we) begin
      store[port.addr] <= port.wdata;
    end
  end

  // Read data follow the current address one cycle later whenever clkEn is high.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port.rdata <= 8'h00;
    end else if (clkEn) begin
      port.rdata <= store[port.addr];
    end
  end
endmodule : irp_reg_mem

// >>> verilog/irp_target.sv
// Serial bus target that reaches an internal register store through a byte pointer.
// Assumes SCL and SDA arrive asynchronously from pins and that the controller never
// stretches the clock; the SDA pin is open drain and resolved outside.
// Functional notes
// - The port works with serial clocks up to 100 kHz and up to 400 kHz.
// - Only the 7-bit target address 32 hex is answered; other addresses are ignored.
// - Every register read or write acts on the register the pointer names.
// - The pointer steps by one after each register byte read or written.
// - The pointer is eight bits wide and steps from FF hex to 00 hex silently.
// - A write is start, address with bit 0, ack, pointer, ack, acked data bytes, stop.
`timescale 1ns/10ps
module irp_target
  import irp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       clkEn,
  input  wire logic       sys_rst,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic [7:0]      regPtr,
  output logic            selected
);
  irp_mem_if  memBus ();
  irp_state_t state;
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic       sclLast;
  logic       sdaLast;
  logic [3:0] bitCnt;
  logic [7:0] rxShift;
  logic [7:0] txShift;
  logic       readDir;
  logic       hostNack;
  logic       next_sdaOe;
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic       byteIn;
  logic       byteOut;
  logic       ptrLoad;
  logic       ptrInc;

  function automatic logic is_rx(input irp_state_t s);
    return (s == ST_ADDR) || (s == ST_PTR) || (s == ST_WDATA);
  endfunction : is_rx

  function automatic logic is_ack(input irp_state_t s);
    return (s == ST_ADDR_ACK) || (s == ST_PTR_ACK) || (s == ST_WDATA_ACK);
  endfunction : is_ack

  irp_reg_mem u_mem (
    .clk     (clk),
    .clkEn   (clkEn),
    .sys_rst (sys_rst),
    .port    (memBus.mem)
  );

  // Two-stage synchronisers, then one more stage for edge detection.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclSync <= 2'b11;
      sdaSync <= 2'b11;
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
    end else if (clkEn) begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      sclLast <= sclSync[1];
      sdaLast <= sdaSync[1];
    end
  end

  assign sclRise   = sclSync[1] && !sclLast;
  assign sclFall   = !sclSync[1] && sclLast;
  assign startSeen = sclSync[1] && sclLast && sdaLast && !sdaSync[1];
  assign stopSeen  = sclSync[1] && sclLast && !sdaLast && sdaSync[1];
  assign byteIn    = sclFall && is_rx(state) && (bitCnt == BITS_PER_BYTE);
  assign byteOut   = sclFall && (state == ST_RDATA) && (bitCnt == LAST_TX_BIT);
  assign ptrLoad   = byteIn && (state == ST_PTR);
  assign ptrInc    = (byteIn && (state == ST_WDATA)) || byteOut;

  // Memory access always uses the pointer.
  assign memBus.addr  = regPtr;
  assign memBus.wdata = rxShift;
  assign memBus.we    = clkEn && byteIn && (state == ST_WDATA);

  // Byte pointer: loaded by a write, stepped after each data byte, wraps at the top.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regPtr <= PTR_RESET;
    end else if (clkEn) begin
      if (ptrLoad) begin
        regPtr <= rxShift;
      end else if (ptrInc) begin
        regPtr <= 8'(regPtr + PTR_STEP);
      end
    end
  end

  // Receive shifter and host acknowledge sample.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxShift  <= 8'h00;
      hostNack <= 1'b1;
    end else if (clkEn && sclRise) begin
      if (is_rx(state)) begin
        rxShift <= {rxShift[6:0], sdaSync[1]};
      end
      if (state == ST_RACK) begin
        hostNack <= sdaSync[1];
      end
    end
  end

  // Protocol sequencer.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state   <= ST_IDLE;
      bitCnt  <= 4'h0;
      readDir <= 1'b0;
      txShift <= 8'h00;
    end else if (clkEn) begin
      if (startSeen) begin
        state  <= ST_ADDR;
        bitCnt <= 4'h0;
      end else if (stopSeen) begin
        state <= ST_IDLE;
      end else if (sclRise && is_rx(state)) begin
        bitCnt <= 4'(bitCnt + 4'h1);
      end else if (sclFall) begin
        case (state)
          ST_ADDR: begin
            if (bitCnt == BITS_PER_BYTE) begin
              if (rxShift[7:1] == TARGET_ADDR) begin
                state   <= ST_ADDR_ACK;
                readDir <= (rxShift[0] != DIR_WRITE);
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_PTR: begin
            if (bitCnt == BITS_PER_BYTE) begin
              state <= ST_PTR_ACK;
            end
          end
          ST_WDATA: begin
            if (bitCnt == BITS_PER_BYTE) begin
              state <= ST_WDATA_ACK;
            end
          end
          ST_ADDR_ACK: begin
            bitCnt <= 4'h0;
            if (readDir) begin
              state   <= ST_RDATA;
              txShift <= memBus.rdata;
            end else begin
              state <= ST_PTR;
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            bitCnt <= 4'h0;
            state  <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bitCnt == LAST_TX_BIT) begin
              state <= ST_RACK;
            end else begin
              bitCnt  <= 4'(bitCnt + 4'h1);
              txShift <= {txShift[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            bitCnt <= 4'h0;
            if (hostNack) begin
              state <= ST_IDLE;
            end else begin
              state   <= ST_RDATA;
              txShift <= memBus.rdata;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain data pin: pull low for acks and for zero bits of read data.
  always_comb begin
    next_sdaOe = 1'b0;
    if (is_ack(state)) begin
      next_sdaOe = 1'b1;
    end else if (state == ST_RDATA) begin
      next_sdaOe = !txShift[7];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdaOe <= 1'b0;
    end else if (clkEn) begin
      sdaOe <= next_sdaOe;
    end
  end

  assign sdaOut   = 1'b0;
  assign selected = (state != ST_IDLE) && (state != ST_ADDR);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !clkEn);

  addr_match_a: assert property (
    (state == ST_ADDR && byteIn && rxShift[7:1] == TARGET_ADDR && !startSeen && !stopSeen)
      |=> state == ST_ADDR_ACK ##1 sdaOe)
    else $error("matching address not acknowledged");
  addr_other_a: assert property (
    (state == ST_ADDR && byteIn && rxShift[7:1] != TARGET_ADDR && !startSeen && !stopSeen)
      |=> state == ST_IDLE ##1 !sdaOe)
    else $error("foreign address not ignored");
  ptr_load_a: assert property (
    ptrLoad |=> regPtr == $past(rxShift))
    else $error("pointer not loaded from first byte");
  write_target_a: assert property (
    (memBus.we && state == ST_WDATA) |=> regPtr == 8'($past(memBus.addr) + PTR_STEP))
    else $error("write not aimed at pointer");
  ptr_step_a: assert property (
    (ptrInc && !ptrLoad) |=> regPtr == 8'($past(regPtr) + PTR_STEP))
    else $error("pointer did not step by one");
  ptr_wrap_a: assert property (
    (ptrInc && regPtr == PTR_TOP) |=> regPtr == PTR_RESET)
    else $error("pointer did not wrap to zero");
  read_end_a: assert property (
    (state == ST_RACK && sclFall && hostNack && !startSeen && !stopSeen)
      |=> state == ST_IDLE ##1 !sdaOe)
    else $error("read not ended on nack");
  stop_release_a: assert property (
    stopSeen |-> ##[1:2] (state == ST_IDLE) ##1 !sdaOe)
    else $error("stop did not release the bus");
  ack_drive_a: assert property (
    (is_ack(state) && $stable(state)) |-> sdaOe)
    else $error("acknowledge not driven");

  write_seen_c: cover property (memBus.we ##[1:300] stopSeen);
  read_more_c:  cover property (state == ST_RACK && sclFall && !hostNack);
  wrap_seen_c:  cover property (ptrInc && regPtr == PTR_TOP);
endmodule : irp_target

// >>> tb/irp_host_model.sv
// Serial bus controller model that frames transfers toward the target.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps
module irp_host_model
  import irp_pkg::*;
(
  input  wire logic clk,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaDrv
);
  int half = FAST_SCL_CYC / 2;

  initial begin
    scl    = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sdaDrv <= 1'b1;
    tick(half);
    scl <= 1'b1;
    tick(half);
    sdaDrv <= 1'b0;
    tick(half);
    scl <= 1'b0;
    tick(half);
  endtask : start

  task automatic stop();
    sdaDrv <= 1'b0;
    tick(half);
    scl <= 1'b1;
    tick(half);
    sdaDrv <= 1'b1;
    tick(half);
  endtask : stop

  // Data changes only while the clock is low and is held past its fall.
  task automatic bitx(input logic b, output logic r);
    sdaDrv <= b;
    tick(half);
    scl <= 1'b1;
    tick(half);
    r = sdaWire;
    scl <= 1'b0;
    tick(1);
  endtask : bitx

  task automatic xfer(input logic [7:0] d, input logic ackIn,
                      output logic [7:0] q, output logic ackOut);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(ackIn, ackOut);
  endtask : xfer
endmodule : irp_host_model

// >>> tb/testbench.sv
// Self-checking bench for the register-pointer serial target.
// Assumes the host model and a pulled-up data wire stand at the far side.
`timescale 1ns/10ps
module testbench
  import irp_pkg::*;
;
  typedef struct {int half; logic [7:0] ptr; logic [7:0] data; int n;} irp_row_t;

  logic       clk;
  logic       clkEn   = 1'b1;
  logic       sys_rst = 1'b1;
  logic       scl;
  logic       sdaDrv;
  logic       sdaOut;
  logic       sdaOe;
  logic       selected;
  logic [7:0] regPtr;
  logic [7:0] q;
  logic       a;
  wire        sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);
  int         errCount;
  int         nCompared;
  irp_row_t   rows [4] = '{'{FAST_SCL_CYC / 2, 8'h88, 8'hA5, 4},
                           '{STD_SCL_CYC / 2, 8'h10, 8'h3C, 1},
                           '{FAST_SCL_CYC / 2, 8'hFE, 8'h70, 3},
                           '{FAST_SCL_CYC / 2, 8'h00, 8'h01, 2}};

  irp_host_model host (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv));

  irp_target dut (
    .clk      (clk),
    .clkEn    (clkEn),
    .sys_rst  (sys_rst),
    .sclIn    (scl),
    .sdaIn    (sdaWire),
    .sdaOut   (sdaOut),
    .sdaOe    (sdaOe),
    .regPtr   (regPtr),
    .selected (selected)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic results();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic doRst();
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({5'h00, sdaOut, sdaOe, selected}, 8'h00, "idle outputs after reset");
    chk(regPtr, 8'h00, "pointer after reset");
  endtask : doRst

  task automatic wr(input logic [7:0] p, input logic [7:0] d, input int n);
    host.start();
    host.xfer({TARGET_ADDR, DIR_WRITE}, 1'b1, q, a);
    chk({7'h00, a}, 8'h00, "address not acked");
    chk({7'h00, selected}, 8'h01, "not selected");
    host.xfer(p, 1'b1, q, a);
    chk({7'h00, a}, 8'h00, "pointer not acked");
    chk(regPtr, p, "pointer load");
    for (int i = 0; i < n; i++) begin
      host.xfer(d + 8'(i), 1'b1, q, a);
      chk({7'h00, a}, 8'h00, "data not acked");
    end
    chk(regPtr, p + 8'(n), "pointer after write");
    host.stop();
    chk({7'h00, selected}, 8'h00, "selected after stop");
  endtask : wr

  task automatic rd(input logic [7:0] p, input logic [7:0] d, input int n);
    host.start();
    host.xfer({TARGET_ADDR, DIR_WRITE}, 1'b1, q, a);
    host.xfer(p, 1'b1, q, a);
    host.start();
    host.xfer({TARGET_ADDR, ~DIR_WRITE}, 1'b1, q, a);
    chk({7'h00, a}, 8'h00, "read address not acked");
    for (int i = 0; i < n; i++) begin
      host.xfer(8'hFF, 1'(i == n - 1), q, a);
      chk(q, d + 8'(i), "read data");
    end
    chk(regPtr, p + 8'(n), "pointer after read");
    host.stop();
  endtask : rd

  initial begin
    repeat (60000) @(posedge clk);
    errCount++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end

  initial begin
    doRst();
    foreach (rows[i]) begin
      host.half = rows[i].half;
      wr(rows[i].ptr, rows[i].data, rows[i].n);
      rd(rows[i].ptr, rows[i].data, rows[i].n);
    end
    host.half = FAST_SCL_CYC / 2;
    doRst();
    host.start();
    host.xfer({TARGET_ADDR, DIR_WRITE}, 1'b1, q, a);
    host.xfer(8'h44, 1'b1, q, a);
    doRst();
    host.xfer(8'h99, 1'b1, q, a);
    chk({7'h00, a}, 8'h01, "data acked after mid-frame reset");
    host.stop();
    chk(regPtr, 8'h00, "pointer after mid-frame reset");
    wr(8'h5A, 8'h00, 0);
    host.start();
    host.xfer({7'h33, DIR_WRITE}, 1'b1, q, a);
    chk({7'h00, a}, 8'h01, "foreign address acked");
    chk({7'h00, selected}, 8'h00, "foreign address selected");
    host.xfer(8'h20, 1'b1, q, a);
    chk(regPtr, 8'h5A, "foreign write moved pointer");
    host.stop();
    clkEn <= 1'b0;
    host.start();
    host.xfer({TARGET_ADDR, DIR_WRITE}, 1'b1, q, a);
    chk({7'h00, a}, 8'h01, "frozen port acked");
    chk({7'h00, selected}, 8'h00, "frozen port selected");
    host.xfer(8'h77, 1'b1, q, a);
    host.stop();
    chk(regPtr, 8'h5A, "frozen port moved pointer");
    clkEn <= 1'b1;
    wr(8'hFF, 8'hC3, 2);
    rd(8'hFF, 8'hC3, 2);
    results();
  end
endmodule : testbench
